// File: hw/adcsq_top.sv
`timescale 1ns/1ps
// Function
// - Wait tracking interval after channel change.
// - Hold channel fixed cycles after start.
// - Divider 0 gives /2, 255 gives /512.
// - Low resolution gives 8-bit, upper bits zero.
// - Store result per channel and last.
// - Tag puts channel number in last.
// - Completion sets done, available; DMA request only if available was clear.
// - Reading results clears done, available flags.
// - Unread channel result overwritten sets overrun.
// - Store while available set sets global overrun.
// - Reading flag registers clears overrun flags.
// - Start bit one triggers, zero ignored.
// - Trigger select chooses edge, continuous, periodic.
// - Hardware trigger delay two clocks minimum.
// - One trigger converts all enabled slots; in natural order these are the enabled channels.
// - DMA carries only results of enabled slots.
// - Sleep powers cell per sequence, off when idle.
// - Custom order slots define up to twelve.
// - Slot active only with paired enable.
// - Tagged DMA word has channel in top.
// - Normal mode keeps analog cell powered.
module adcsq_top
  import adcsq_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic [7:0]        addr,
  input  wire logic [31:0]       wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [31:0]       rdata,
  input  wire logic              trig_pin,
  input  wire logic [DW-1:0]     conv_data,
  output logic                   cell_power,
  output logic                   cell_start,
  output logic      [3:0]        mux_sel,
  output adcsq_dma_t             dma
);

  function automatic logic is_cdr(input logic [7:0] a);
    return (a >= OFF_CDR0) && (a <= OFF_CDR11) && (a[1:0] == 2'b00);
  endfunction

  function automatic logic [3:0] cdr_idx(input logic [7:0] a);
    logic [7:0] d;
    d = a - OFF_CDR0;
    return d[5:2];
  endfunction

  // Configuration and status state.
  adcsq_mode_t     mode_q, mode_d;
  logic [47:0]     seq_q, seq_d;
  logic [NCH-1:0]  chen_q, chen_d;
  logic            tag_q, tag_d;
  adcsq_trg_t      trg_q, trg_d;
  logic [15:0]     per_q, per_d;
  logic [DW-1:0]   cdr_q [NCH];
  logic [DW-1:0]   cdr_d [NCH];
  logic [DW-1:0]   last_q, last_d;
  logic [3:0]      lchn_q, lchn_d;
  logic [NCH-1:0]  eoc_q, eoc_d;
  logic [NCH-1:0]  ovr_q, ovr_d;
  logic            result_available_flag_q, result_available_flag_d;
  logic            global_overrun_flag_q, global_overrun_flag_d;
  logic [31:0]     rdata_d;
  adcsq_dma_t      dma_d;

  // Sequencer state.
  adcsq_st_t       st_q, st_d;
  logic [3:0]      slot_q, slot_d;
  logic [3:0]      ch_q, ch_d;
  logic [11:0]     cnt_q, cnt_d;
  logic [8:0]      pre_q, pre_d;
  logic            cclk_q, cclk_d;
  logic [15:0]     pcnt_q, pcnt_d;
  logic            pwr_q, pwr_d;
  logic            done_pulse;
  logic [DW-1:0]   res;

  // Trigger pin synchroniser; the first stage feeds only the second.
  logic            sy1_q, sy2_q, sy3_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sy1_q <= 1'b0;
      sy2_q <= 1'b0;
      sy3_q <= 1'b0;
    end else begin
      sy1_q <= trig_pin;
      sy2_q <= sy1_q;
      sy3_q <= sy2_q;
    end
  end

  logic hw_trig;
  logic sw_trig;
  logic trig;
  always_comb begin
    hw_trig = 1'b0;
    case (trg_q)
      TRG_RISE:   hw_trig = sy2_q & ~sy3_q;
      TRG_FALL:   hw_trig = ~sy2_q & sy3_q;
      TRG_ANY:    hw_trig = sy2_q ^ sy3_q;
      TRG_CONT:   hw_trig = 1'b1;
      TRG_PERIOD: hw_trig = (pcnt_q >= per_q);
      default:    hw_trig = 1'b0;
    endcase
    sw_trig = wr && (addr == OFF_CMD) && wdata[CMD_START];
    trig = hw_trig | sw_trig;
  end

  // Slot selection: natural order or the custom table.
  function automatic logic [3:0] slot_ch(input logic [3:0] s, input logic [47:0] t,
                                         input logic u);
    return u ? t[s*4 +: 4] : s;
  endfunction

  // Next active slot at or after s; NCH when none.
  logic [3:0] nxt_from_start;
  logic [3:0] nxt_from_slot;
  function automatic logic [3:0] find_slot(input logic [3:0] s, input logic [NCH-1:0] en);
    logic [3:0] r;
    r = 4'(NCH);
    for (int i = NCH - 1; i >= 0; i--) begin
      if (4'(i) >= s && en[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  always_comb begin
    nxt_from_start = find_slot(4'h0, chen_q);
    nxt_from_slot  = find_slot(slot_q + 4'h1, chen_q);
  end

  // Sequencer and conversion clock divider.
  always_comb begin
    st_d       = st_q;
    slot_d     = slot_q;
    ch_d       = ch_q;
    cnt_d      = cnt_q;
    pwr_d      = pwr_q;
    done_pulse = 1'b0;
    cell_start = 1'b0;
    pcnt_d     = (trg_q == TRG_PERIOD && pcnt_q < per_q) ? pcnt_q + 16'h1 : 16'h0;
    // Compared with >= so that a smaller divider written mid-count cannot stall a full wrap.
    if (pre_q >= {mode_q.div, 1'b0} + 9'h1) begin
      pre_d  = 9'h0;
      cclk_d = 1'b1;
    end else begin
      pre_d  = pre_q + 9'h1;
      cclk_d = 1'b0;
    end
    case (st_q)
      ST_IDLE: begin
        pwr_d = ~mode_q.sleep;
        if (trig && nxt_from_start != 4'(NCH)) begin
          slot_d = nxt_from_start;
          ch_d   = slot_ch(nxt_from_start, seq_q, mode_q.custom_order_enable);
          pwr_d  = 1'b1;
          cnt_d  = mode_q.sleep ? 12'(mode_q.startup * STU_MUL) : 12'h0;
          st_d   = ST_START;
        end
      end
      ST_START: begin
        if (cnt_q == 12'h0) begin
          cnt_d = {8'h0, mode_q.track};
          st_d  = ST_TRACK;
        end else if (cclk_q) begin
          cnt_d = cnt_q - 12'h1;
        end
      end
      ST_TRACK: begin
        if (cnt_q == 12'h0) begin
          cell_start = 1'b1;
          cnt_d      = {8'h0, HOLD_CYC};
          st_d       = ST_HOLD;
        end else if (cclk_q) begin
          cnt_d = cnt_q - 12'h1;
        end
      end
      ST_HOLD: begin
        if (cnt_q == 12'h0) begin
          cnt_d = {8'h0, CONV_CYC - HOLD_CYC};
          st_d  = ST_CONV;
        end else if (cclk_q) begin
          cnt_d = cnt_q - 12'h1;
        end
      end
      ST_CONV: begin
        if (cnt_q == 12'h0) begin
          done_pulse = 1'b1;
          st_d       = ST_NEXT;
        end else if (cclk_q) begin
          cnt_d = cnt_q - 12'h1;
        end
      end
      ST_NEXT: begin
        if (nxt_from_slot == 4'(NCH) || slot_q == 4'(NCH - 1)) begin
          st_d  = ST_IDLE;
          pwr_d = ~mode_q.sleep;
        end else begin
          slot_d = nxt_from_slot;
          ch_d   = slot_ch(nxt_from_slot, seq_q, mode_q.custom_order_enable);
          cnt_d  = {8'h0, mode_q.track};
          st_d   = ST_TRACK;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  // Registers, flags and read path.
  always_comb begin
    mode_d  = mode_q;
    seq_d   = seq_q;
    chen_d  = chen_q;
    tag_d   = tag_q;
    trg_d   = trg_q;
    per_d   = per_q;
    last_d  = last_q;
    lchn_d  = lchn_q;
    eoc_d   = eoc_q;
    ovr_d   = ovr_q;
    result_available_flag_d  = result_available_flag_q;
    global_overrun_flag_d = global_overrun_flag_q;
    rdata_d = 32'h0;
    for (int i = 0; i < NCH; i++) begin
      cdr_d[i] = cdr_q[i];
    end
    res = mode_q.low_resolution_select ? {2'b00, conv_data[DW-1:2]} : conv_data;
    if (wr) begin
      case (addr)
        OFF_MODE: begin
          mode_d.custom_order_enable    = wdata[MODE_CUSTOM_ORDER_ENABLE];
          mode_d.track   = wdata[MODE_TRK_LO +: 4];
          mode_d.startup = wdata[MODE_STU_LO +: 4];
          mode_d.div     = wdata[MODE_DIV_LO +: 8];
          mode_d.sleep   = wdata[MODE_SLEEP];
          mode_d.low_resolution_select  = wdata[MODE_LOW_RESOLUTION_SELECT];
        end
        OFF_SEQ1:  seq_d[31:0] = wdata;
        OFF_SEQ2:  seq_d[47:32] = wdata[15:0];
        OFF_CHEN:  chen_d = chen_q | wdata[NCH-1:0];
        OFF_CHDIS: chen_d = chen_q & ~wdata[NCH-1:0];
        OFF_EXT:   tag_d = wdata[EXT_TAG];
        OFF_TRIG: begin
          trg_d = adcsq_trg_t'(wdata[2:0]);
          per_d = wdata[TRG_PER_LO +: 16];
        end
        default: ;
      endcase
    end
    if (rd) begin
      case (addr)
        OFF_MODE:  rdata_d = {mode_q.custom_order_enable, 3'b000, mode_q.track, 4'h0, mode_q.startup,
                              mode_q.div, 2'b00, mode_q.sleep, mode_q.low_resolution_select, 4'h0};
        OFF_SEQ1:  rdata_d = seq_q[31:0];
        OFF_SEQ2:  rdata_d = {16'h0, seq_q[47:32]};
        OFF_CHST:  rdata_d = {20'h0, chen_q};
        OFF_LAST: begin
          rdata_d = {16'h0, tag_q ? lchn_q : 4'h0, 2'b00, last_q};
          result_available_flag_d  = 1'b0;
        end
        OFF_FLAGS: begin
          rdata_d = {6'h0, global_overrun_flag_q, result_available_flag_q, 12'h0, eoc_q};
          global_overrun_flag_d = 1'b0;
        end
        OFF_OVR: begin
          rdata_d = {20'h0, ovr_q};
          ovr_d   = '0;
        end
        OFF_EXT:   rdata_d = {7'h0, tag_q, 24'h0};
        OFF_TRIG:  rdata_d = {per_q, 13'h0, trg_q};
        default: begin
          if (is_cdr(addr)) begin
            rdata_d = {22'h0, cdr_q[cdr_idx(addr)]};
            eoc_d[cdr_idx(addr)] = 1'b0;
          end
        end
      endcase
    end
    // A completion after the clears above, so a simultaneous set wins.
    if (done_pulse) begin
      cdr_d[ch_q] = res;
      last_d      = res;
      lchn_d      = ch_q;
      if (eoc_q[ch_q]) begin
        ovr_d[ch_q] = 1'b1;
      end
      if (result_available_flag_q) begin
        global_overrun_flag_d = 1'b1;
      end
      eoc_d[ch_q] = 1'b1;
      result_available_flag_d      = 1'b1;
    end
    dma_d.req  = done_pulse & ~result_available_flag_q;
    dma_d.data = {tag_q ? ch_q : 4'h0, 2'b00, res};
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_q  <= '0;
      seq_q   <= '0;
      chen_q  <= '0;
      tag_q   <= 1'b0;
      trg_q   <= TRG_NONE;
      per_q   <= '0;
      last_q  <= '0;
      lchn_q  <= '0;
      eoc_q   <= '0;
      ovr_q   <= '0;
      result_available_flag_q  <= 1'b0;
      global_overrun_flag_q <= 1'b0;
      rdata   <= '0;
      dma     <= '0;
      st_q    <= ST_IDLE;
      slot_q  <= '0;
      ch_q    <= '0;
      cnt_q   <= '0;
      pre_q   <= '0;
      cclk_q  <= 1'b0;
      pcnt_q  <= '0;
      pwr_q   <= 1'b1;
      for (int i = 0; i < NCH; i++) begin
        cdr_q[i] <= '0;
      end
    end else begin
      mode_q  <= mode_d;
      seq_q   <= seq_d;
      chen_q  <= chen_d;
      tag_q   <= tag_d;
      trg_q   <= trg_d;
      per_q   <= per_d;
      last_q  <= last_d;
      lchn_q  <= lchn_d;
      eoc_q   <= eoc_d;
      ovr_q   <= ovr_d;
      result_available_flag_q  <= result_available_flag_d;
      global_overrun_flag_q <= global_overrun_flag_d;
      rdata   <= rdata_d;
      dma     <= dma_d;
      st_q    <= st_d;
      slot_q  <= slot_d;
      ch_q    <= ch_d;
      cnt_q   <= cnt_d;
      pre_q   <= pre_d;
      cclk_q  <= cclk_d;
      pcnt_q  <= pcnt_d;
      pwr_q   <= pwr_d;
      for (int i = 0; i < NCH; i++) begin
        cdr_q[i] <= cdr_d[i];
      end
    end
  end

  assign cell_power = pwr_q;
  assign mux_sel    = ch_q;

  a_done_sets_flags: assert property (@(posedge clk) disable iff (!rstn)
    done_pulse |=> result_available_flag_q && eoc_q[$past(ch_q)]) else $error("flags not set");
  a_last_rd_clears: assert property (@(posedge clk) disable iff (!rstn)
    (rd && addr == OFF_LAST && !done_pulse) |=> !result_available_flag_q) else $error("result_available_flag not cleared");
  a_global_overrun_flag_on_result_available_flag: assert property (@(posedge clk) disable iff (!rstn)
    (done_pulse && result_available_flag_q) |=> global_overrun_flag_q) else $error("global_overrun_flag missing");
  a_ovr_on_eoc: assert property (@(posedge clk) disable iff (!rstn)
    (done_pulse && eoc_q[ch_q]) |=> ovr_q[$past(ch_q)]) else $error("overrun missing");
  a_ovr_rd_clears: assert property (@(posedge clk) disable iff (!rstn)
    (rd && addr == OFF_OVR && !done_pulse) |=> ovr_q == '0) else $error("ovr not cleared");
  a_low_resolution_select_top_zero: assert property (@(posedge clk) disable iff (!rstn)
    (done_pulse && mode_q.low_resolution_select) |=> last_q[DW-1:DW-2] == 2'b00) else $error("low_resolution_select bits");
  a_sw_start: assert property (@(posedge clk) disable iff (!rstn)
    (st_q == ST_IDLE && sw_trig && chen_q != '0) |=> st_q == ST_START) else $error("no start");
  a_sleep_power: assert property (@(posedge clk) disable iff (!rstn)
    (st_q == ST_IDLE && !$past(mode_q.sleep) && $past(st_q) == ST_IDLE) |-> cell_power)
    else $error("cell off in normal mode");
  a_dma_edge: assert property (@(posedge clk) disable iff (!rstn)
    dma.req |-> $past(done_pulse) && !$past(result_available_flag_q)) else $error("dma spurious");

  c_seq_done:  cover property (@(posedge clk) disable iff (!rstn) st_q == ST_NEXT ##1 st_q == ST_IDLE);
  c_overrun:   cover property (@(posedge clk) disable iff (!rstn) global_overrun_flag_q);
  c_sleep_seq: cover property (@(posedge clk) disable iff (!rstn) mode_q.sleep && st_q == ST_START);
  c_custom:    cover property (@(posedge clk) disable iff (!rstn) mode_q.custom_order_enable && done_pulse);

endmodule // adcsq_top

// File: include/adcsq_pkg.sv
package adcsq_pkg;

  localparam int NCH = 12;
  localparam int DW  = 10;

  // Register offsets (byte addresses on the plain register port).
  localparam logic [7:0] OFF_CMD   = 8'h00;
  localparam logic [7:0] OFF_MODE  = 8'h04;
  localparam logic [7:0] OFF_SEQ1  = 8'h08;
  localparam logic [7:0] OFF_SEQ2  = 8'h0C;
  localparam logic [7:0] OFF_CHEN  = 8'h10;
  localparam logic [7:0] OFF_CHDIS = 8'h14;
  localparam logic [7:0] OFF_CHST  = 8'h18;
  localparam logic [7:0] OFF_LAST  = 8'h20;
  localparam logic [7:0] OFF_FLAGS = 8'h30;
  localparam logic [7:0] OFF_OVR   = 8'h3C;
  localparam logic [7:0] OFF_EXT   = 8'h40;
  localparam logic [7:0] OFF_CDR0  = 8'h50;
  localparam logic [7:0] OFF_CDR11 = 8'h7C;
  localparam logic [7:0] OFF_TRIG  = 8'hC0;

  // Field positions.
  localparam int CMD_START   = 1;
  localparam int MODE_LOW_RESOLUTION_SELECT = 4;
  localparam int MODE_SLEEP  = 5;
  localparam int MODE_DIV_LO = 8;
  localparam int MODE_STU_LO = 16;
  localparam int MODE_TRK_LO = 24;
  localparam int MODE_CUSTOM_ORDER_ENABLE   = 31;
  localparam int EXT_TAG     = 24;
  localparam int TRG_PER_LO  = 16;
  localparam int CHANNEL_NUMBER_FIELD_LO     = 12;
  localparam int FLG_RESULT_AVAILABLE_FLAG    = 24;
  localparam int FLG_GLOBAL_OVERRUN_FLAG   = 25;

  // Fixed timing in conversion clock cycles.
  localparam logic [3:0] HOLD_CYC = 4'h3;
  localparam logic [3:0] CONV_CYC = 4'hA;
  localparam logic [7:0] STU_MUL  = 8'h08;

  typedef enum logic [2:0] {
    TRG_NONE  = 3'b000,
    TRG_RISE  = 3'b001,
    TRG_FALL  = 3'b010,
    TRG_ANY   = 3'b011,
    TRG_CONT  = 3'b110,
    TRG_PERIOD= 3'b101
  } adcsq_trg_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_START = 3'b001,
    ST_TRACK = 3'b010,
    ST_HOLD  = 3'b011,
    ST_CONV  = 3'b100,
    ST_NEXT  = 3'b101
  } adcsq_st_t;

  typedef struct packed {
    logic        custom_order_enable;
    logic [3:0]  track;
    logic [3:0]  startup;
    logic [7:0]  div;
    logic        sleep;
    logic        low_resolution_select;
  } adcsq_mode_t;

  typedef struct packed {
    logic        req;
    logic [15:0] data;
  } adcsq_dma_t;

endpackage

// File: test/adcsq_src.sv
`timescale 1ns/1ps
module adcsq_src
  import adcsq_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          cell_power,
  input  wire logic [3:0]    mux_sel,
  output logic      [DW-1:0] conv_data
);
  logic [DW-1:0] junk_q = 10'h155;
  // An unpowered cell has no valid level, so a moving pattern stands in for it.
  always_ff @(posedge clk) junk_q <= ~junk_q + 10'h001;
  assign conv_data = cell_power ? {mux_sel, 6'h15} : junk_q;
endmodule // adcsq_src

// File: test/adcsq_top_tb_top.sv
`timescale 1ns/1ps
module adcsq_top_tb_top
  import adcsq_pkg::*;
;
  logic            clk = 1'b0;
  logic            rstn = 1'b0;
  logic            wr = 1'b0;
  logic            rd = 1'b0;
  logic            trig = 1'b0;
  logic [7:0]      addr = 8'h00;
  logic [31:0]     wdata = 32'h0;
  logic [31:0]     rdata;
  logic [31:0]     got;
  logic [DW-1:0]   conv_data;
  logic            cell_power;
  logic            cell_start;
  logic [3:0]      mux_sel;
  adcsq_dma_t      dma;
  logic [15:0]     dma_last;
  logic [4:0]      log_q[$];
  int              t_q[$];
  int              cyc = 0;
  int              dma_n = 0;
  int              div_n = 0;
  int              errors = 0;
  int              n_checks = 0;

  always #10 clk = ~clk;

  adcsq_top dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .trig_pin(trig), .conv_data(conv_data), .cell_power(cell_power),
    .cell_start(cell_start), .mux_sel(mux_sel), .dma(dma));
  adcsq_src src (.clk(clk), .cell_power(cell_power), .mux_sel(mux_sel),
    .conv_data(conv_data));

  // Sampled on the falling edge, where the combinational start pulse has settled.
  always @(negedge clk) begin
    cyc++;
    if (cell_start === 1'b1) begin
      log_q.push_back({cell_power, mux_sel});
      t_q.push_back(cyc);
    end
    if (dma.req === 1'b1) begin
      dma_n++;
      dma_last = dma.data;
    end
  end

  function automatic logic [31:0] res(input logic [3:0] ch, input logic tag);
    return {16'h0, tag ? ch : 4'h0, 2'b00, ch, 6'h15};
  endfunction

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 got = rdata;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    rd_reg(a);
    chk(what, got, exp);
  endtask

  // The wait after the last start covers hold plus conversion, so triggers stay spaced.
  task automatic run(input int n);
    int i;
    for (i = 0; i < 5000 && log_q.size() < n; i++) @(posedge clk);
    repeat (20 * (div_n + 1) + 6) @(posedge clk);
    chk("starts", log_q.size(), n);
  endtask

  task automatic t_reset();
    chk("power", cell_power, 1'b1);
    chk("mux", mux_sel, 4'h0);
    rd_chk("flags", OFF_FLAGS, 32'h0);
    rd_chk("last", OFF_LAST, 32'h0);
    rd_chk("unmapped", 8'h24, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_natural();
    wr_reg(OFF_EXT, 32'h0100_0000);
    wr_reg(OFF_CHEN, 32'h5);
    rd_chk("enabled", OFF_CHST, 32'h5);
    wr_reg(OFF_CMD, 32'h0);
    run(0);
    wr_reg(OFF_CMD, 32'h2);
    run(2);
    chk("first", log_q[0], 5'h10);
    chk("second", log_q[1], 5'h12);
    chk("dma", dma_last, res(4'h0, 1'b1));
    chk("dma count", dma_n, 1);
    rd_chk("flags", OFF_FLAGS, 32'h0300_0005);
    rd_chk("flags", OFF_FLAGS, 32'h0100_0005);
    rd_chk("last", OFF_LAST, res(4'h2, 1'b1));
    rd_chk("cdr2", OFF_CDR0 + 8'h08, res(4'h2, 1'b0));
    rd_chk("flags", OFF_FLAGS, 32'h0000_0001);
    $display("test natural done");
  endtask

  task automatic t_overrun();
    log_q.delete();
    wr_reg(OFF_CMD, 32'h2);
    run(2);
    rd_chk("overrun", OFF_OVR, 32'h1);
    rd_chk("overrun", OFF_OVR, 32'h0);
    rd_chk("flags", OFF_FLAGS, 32'h0300_0005);
    chk("dma count", dma_n, 2);
    $display("test overrun done");
  endtask

  task automatic t_low_resolution_select();
    log_q.delete();
    wr_reg(OFF_CHDIS, 32'h4);
    wr_reg(OFF_MODE, 32'h0000_0010);
    wr_reg(OFF_CMD, 32'h2);
    run(1);
    rd_reg(OFF_CDR0);
    chk("cdr0 top", got[9:8], 2'b00);
    chk("cdr0 upper", got[31:10], 22'h0);
    chk("cdr0 value", got, 32'h0000_0005);
    rd_reg(OFF_LAST);
    chk("last top", got[9:8], 2'b00);
    chk("last value", got, 32'h0000_0005);
    $display("test low_resolution_select done");
  endtask

  task automatic t_custom();
    log_q.delete();
    wr_reg(OFF_CHEN, 32'hF);
    wr_reg(OFF_SEQ1, 32'h0001_0133);
    wr_reg(OFF_MODE, 32'h8000_0000);
    wr_reg(OFF_CMD, 32'h2);
    run(4);
    chk("slot0", log_q[0], 5'h13);
    chk("slot1", log_q[1], 5'h13);
    chk("slot2", log_q[2], 5'h11);
    chk("slot3", log_q[3], 5'h10);
    rd_chk("last", OFF_LAST, res(4'h0, 1'b1));
    chk("dma tag", dma_last, res(4'h3, 1'b1));
    $display("test custom done");
  endtask

  task automatic t_div();
    log_q.delete();
    t_q.delete();
    div_n = 2;
    wr_reg(OFF_MODE, 32'h0000_0200);
    wr_reg(OFF_CMD, 32'h2);
    run(4);
    chk("tick align", (t_q[3] - t_q[1]) % 6, 0);
    chk("span", t_q[2] - t_q[1], 60);
    chk("min gap", (t_q[2] - t_q[1]) >= 60, 1'b1);
    div_n = 0;
    $display("test divider done");
  endtask

  task automatic t_ext();
    int t0;
    log_q.delete();
    t_q.delete();
    wr_reg(OFF_MODE, 32'h0);
    wr_reg(OFF_CHDIS, 32'hE);
    wr_reg(OFF_TRIG, 32'h1);
    @(posedge clk);
    trig <= 1'b1;
    t0 = cyc;
    run(1);
    chk("sync delay", (t_q[0] - t0) >= 2, 1'b1);
    @(posedge clk);
    trig <= 1'b0;
    run(1);
    wr_reg(OFF_TRIG, 32'h2);
    @(posedge clk);
    trig <= 1'b1;
    @(posedge clk);
    trig <= 1'b0;
    run(2);
    wr_reg(OFF_TRIG, 32'h0);
    $display("test external done");
  endtask

  // Periodic, continuous and either-edge triggers, each stopped before the next mode.
  task automatic t_auto();
    log_q.delete();
    t_q.delete();
    wr_reg(OFF_TRIG, 32'h0064_0005);
    run(2);
    chk("period", ((t_q[1] - t_q[0]) >= 100) && ((t_q[1] - t_q[0]) <= 101), 1'b1);
    wr_reg(OFF_TRIG, 32'h0);
    log_q.delete();
    wr_reg(OFF_TRIG, 32'h6);
    repeat (150) @(posedge clk);
    wr_reg(OFF_TRIG, 32'h0);
    chk("restarts", log_q.size() >= 4, 1'b1);
    repeat (40) @(posedge clk);
    log_q.delete();
    wr_reg(OFF_TRIG, 32'h3);
    @(posedge clk);
    trig <= 1'b1;
    run(1);
    @(posedge clk);
    trig <= 1'b0;
    run(2);
    wr_reg(OFF_TRIG, 32'h0);
    $display("test auto done");
  endtask

  task automatic t_sleep();
    int t0;
    log_q.delete();
    t_q.delete();
    wr_reg(OFF_MODE, 32'h0001_0020);
    t0 = cyc;
    wr_reg(OFF_CMD, 32'h2);
    wr_reg(OFF_CMD, 32'h2);
    run(1);
    chk("startup wait", (t_q[0] - t0) >= 16, 1'b1);
    chk("awake", log_q[0], 5'h10);
    chk("asleep", cell_power, 1'b0);
    $display("test sleep done");
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    tally_and_finish();
  end

  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_natural();
    t_overrun();
    t_low_resolution_select();
    t_custom();
    t_div();
    t_ext();
    t_auto();
    t_sleep();
    tally_and_finish();
  end
endmodule // adcsq_top_tb_top
